// file: hw/hvpl_pkg.sv
package hvpl_pkg;

    // Register indices (printed offsets are not word multiples)
    localparam logic [15:0] IDX_FAULT0     = 16'hA042;
    localparam logic [15:0] IDX_DIVSEL0    = 16'hA043;
    localparam logic [15:0] IDX_GENCFG1    = 16'hA044;
    localparam logic [15:0] IDX_LEDCFG1    = 16'hA045;
    localparam logic [15:0] IDX_FAULT1     = 16'hA046;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hA050;
    localparam logic [15:0] IDX_IRQ_CLEAR  = 16'hA051;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'hA052;

    // Fault register field positions
    localparam int FB_FILTER   = 7;
    localparam int FB_IRQ_EN   = 6;
    localparam int FB_OPEN_EN  = 5;
    localparam int FB_SHORT_EN = 4;
    localparam int FB_OPEN_LV  = 3;
    localparam int FB_SHORT_LV = 2;
    localparam int FB_OPEN_FL  = 1;
    localparam int FB_SHORT_FL = 0;

    // General configuration field positions, channel 1
    localparam int GB_I2C_CLK  = 7;
    localparam int GB_ADC      = 6;
    localparam int GB_SPI_CLK  = 5;
    localparam int GB_PORT     = 4;
    localparam int GB_PWM      = 3;
    localparam int GB_ATTEN    = 2;
    localparam int GB_INBUF    = 1;
    localparam int GB_PULLUP   = 0;

    // LED configuration field positions
    localparam int LB_SINK_EN  = 7;
    localparam int LB_TRIM_LSB = 0;
    localparam int LB_TRIM_W   = 5;

    // Interrupt status bit positions
    localparam int IB_SHORT0 = 0;
    localparam int IB_OPEN0  = 1;
    localparam int IB_SHORT1 = 2;
    localparam int IB_OPEN1  = 3;

    // Reset values
    localparam logic [7:0] RST_FAULT  = 8'h00;
    localparam logic [7:0] RST_DIVSEL = 8'h00;
    localparam logic [7:0] RST_GENCFG = 8'h00;
    localparam logic [7:0] RST_LEDCFG = 8'h00;
    localparam logic [3:0] RST_IRQ    = 4'h0;

    // Filter length in PWM periods
    localparam int FILTER_PERIODS = 3;

    // Divider gain encodings
    localparam logic [1:0] DIV_FIFTH = 2'h0;
    localparam logic [1:0] DIV_THIRD = 2'h1;
    localparam logic [1:0] DIV_HALF  = 2'h2;
    localparam logic [1:0] DIV_UNITY = 2'h3;

endpackage

// file: hw/hvpl_fault_chan.sv
`timescale 1ns/1ps
`default_nettype none
module hvpl_fault_chan
    import hvpl_pkg::*;
#(
    parameter int FILT_LEN = FILTER_PERIODS
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic mid_pwm,
    input  wire logic open_raw,
    input  wire logic short_raw,
    input  wire logic filter_en,
    input  wire logic open_en,
    input  wire logic short_en,
    output logic      open_live,
    output logic      short_live,
    output logic      open_event,
    output logic      short_event
);

    // Pin-side synchronisers, a change counts once stages 2 and 3 agree
    logic [2:0] open_sync;
    logic [2:0] short_sync;
    logic       open_stable;
    logic       short_stable;
    logic [2:0] next_open_sync;
    logic [2:0] next_short_sync;
    logic       next_open_stable;
    logic       next_short_stable;

    always_comb begin
        next_open_sync    = {open_sync[1:0], open_raw};
        next_short_sync   = {short_sync[1:0], short_raw};
        next_open_stable  = open_stable;
        next_short_stable = short_stable;
        if (open_sync[1] == open_sync[2]) begin
            next_open_stable = open_sync[2];
        end
        if (short_sync[1] == short_sync[2]) begin
            next_short_stable = short_sync[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            open_sync    <= 3'h0;
            short_sync   <= 3'h0;
            open_stable  <= 1'b0;
            short_stable <= 1'b0;
        end else begin
            open_sync    <= next_open_sync;
            short_sync   <= next_short_sync;
            open_stable  <= next_open_stable;
            short_stable <= next_short_stable;
        end
    end

    // Per-period sampling with optional agreement filter over several periods
    logic [FILT_LEN-1:0] open_hist;
    logic [FILT_LEN-1:0] short_hist;
    logic [FILT_LEN-1:0] next_open_hist;
    logic [FILT_LEN-1:0] next_short_hist;
    logic                next_open_live;
    logic                next_short_live;

    always_comb begin
        next_open_hist  = open_hist;
        next_short_hist = short_hist;
        next_open_live  = open_live;
        next_short_live = short_live;
        if (mid_pwm) begin // RQ4
            next_open_hist  = {open_hist[FILT_LEN-2:0], open_stable};
            next_short_hist = {short_hist[FILT_LEN-2:0], short_stable};
            if (!filter_en) begin
                next_open_live  = open_stable;
                next_short_live = short_stable;
            end else begin
                // Both edges need a full run of agreeing samples
                if (&next_open_hist) next_open_live = 1'b1; // RQ1
                if (~|next_open_hist) next_open_live = 1'b0; // RQ1
                if (&next_short_hist) next_short_live = 1'b1; // RQ1
                if (~|next_short_hist) next_short_live = 1'b0; // RQ1
            end
        end
        // Disabled detectors report nothing
        if (!open_en) next_open_live = 1'b0; // RQ2
        if (!short_en) next_short_live = 1'b0; // RQ3
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            open_hist   <= '0;
            short_hist  <= '0;
            open_live   <= 1'b0;
            short_live  <= 1'b0;
            open_event  <= 1'b0;
            short_event <= 1'b0;
        end else begin
            open_hist   <= next_open_hist;
            short_hist  <= next_short_hist;
            open_live   <= next_open_live;
            short_live  <= next_short_live;
            open_event  <= next_open_live & ~open_live;
            short_event <= next_short_live & ~short_live;
        end
    end

    AST_OPEN_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !open_en |=> !open_live) // RQ2
        else $error("open status set while detection off");
    AST_SHORT_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !short_en |=> !short_live) // RQ3
        else $error("short status set while detection off");
    AST_LIVE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!mid_pwm && open_en && $past(open_en)) |=> $stable(open_live)) // RQ4
        else $error("open status changed off mid period");

endmodule // hvpl_fault_chan
`default_nettype wire

// file: hw/hvpl_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: Filter enabled filters fault assertion and release
// RQ2: Open detect off forces open status low
// RQ3: Short detect off forces short status low
// RQ4: Live status refreshed at mid PWM
// RQ5: Short fault sets flag, interrupts when enabled
// RQ6: Interrupt disabled: short flag only latches
// RQ7: Short flag held until software clears
// RQ8: Open flag behaves like short flag
// RQ9: Divider select gives 1/5,1/3,1/2,1 gain
// RQ10: Pin routes to SPI and I2C clocks
// RQ11: Port enable connects general-purpose port bit
// RQ12: Attenuation enable feeds divide-by-six to converter
// RQ13: Converter enable connects pin to ADC
// RQ14: Sink enable lets PWM switch current sink
// RQ15: Five-bit full-scale trim for sink
// RQ16: Channel 1 fault register mirrors channel 0
// RQ17: Writing zero clears flag, one keeps
module hvpl_regs
    import hvpl_pkg::*;
#(
    parameter int FILT_LEN = FILTER_PERIODS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    // Detector and PWM side
    input  wire logic        mid_pwm,
    input  wire logic        led_pwm_output,
    input  wire logic [1:0]  open_sense,
    input  wire logic [1:0]  short_sense,
    // Analog controls
    output logic [1:0]       sense_divider_select,
    output logic             i2c_clock_route_enable,
    output logic             pin1_converter_enable,
    output logic             spi_clock_route_enable,
    output logic             pin1_port_enable,
    output logic             green_pwm_route_enable,
    output logic             pin1_attenuator_enable,
    output logic             pin1_input_buffer_enable,
    output logic             pin1_pullup_enable,
    output logic             pin1_current_sink_enable,
    output logic [4:0]       pin1_fullscale_trim,
    output logic             pin1_sink_drive,
    output logic             irq
);

    // Word index from register index (low 14 bits)
    function automatic logic [13:0] widx(input logic [15:0] idx);
        return idx[13:0];
    endfunction

    logic [7:0] fault_cfg [2];
    logic [7:0] divsel0;
    logic [7:0] gencfg1;
    logic [7:0] ledcfg1;
    logic [1:0] open_flag;
    logic [1:0] short_flag;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic [1:0] open_live;
    logic [1:0] short_live;
    logic [1:0] open_event;
    logic [1:0] short_event;

    // One fault detector per channel
    for (genvar c = 0; c < 2; c++) begin : g_chan
        hvpl_fault_chan #(
            .FILT_LEN (FILT_LEN)
        ) u_chan (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .mid_pwm     (mid_pwm),
            .open_raw    (open_sense[c]),
            .short_raw   (short_sense[c]),
            .filter_en   (fault_cfg[c][FB_FILTER]), // RQ1
            .open_en     (fault_cfg[c][FB_OPEN_EN]),
            .short_en    (fault_cfg[c][FB_SHORT_EN]),
            .open_live   (open_live[c]),
            .short_live  (short_live[c]),
            .open_event  (open_event[c]),
            .short_event (short_event[c])
        );
    end

    // Bus decode: one wait cycle, answer on the second cycle
    logic        pend;
    logic        next_pend;
    logic [13:0] a;
    logic        wr_go;
    logic        rd_go;
    logic        hit;

    assign a     = avs_address[15:2];
    assign wr_go = avs_write & pend;
    assign rd_go = avs_read & pend;

    always_comb begin
        case (a)
            widx(IDX_FAULT0), widx(IDX_DIVSEL0), widx(IDX_GENCFG1),
            widx(IDX_LEDCFG1), widx(IDX_FAULT1), widx(IDX_IRQ_STATUS),
            widx(IDX_IRQ_CLEAR), widx(IDX_IRQ_ENABLE): hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        next_pend = (avs_read | avs_write) & ~pend;
    end

    // Register state next values
    logic [7:0] next_fault_cfg [2];
    logic [7:0] next_divsel0;
    logic [7:0] next_gencfg1;
    logic [7:0] next_ledcfg1;
    logic [1:0] next_open_flag;
    logic [1:0] next_short_flag;
    logic [3:0] next_irq_status;
    logic [3:0] next_irq_enable;
    logic       wlane;

    always_comb begin
        wlane           = wr_go & avs_byteenable[0];
        next_fault_cfg  = fault_cfg;
        next_divsel0    = divsel0;
        next_gencfg1    = gencfg1;
        next_ledcfg1    = ledcfg1;
        next_open_flag  = open_flag;
        next_short_flag = short_flag;
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        for (int c = 0; c < 2; c++) begin
            // Only the upper enable bits store; live bits ignore writes
            if (wlane && a == (c == 0 ? widx(IDX_FAULT0) : widx(IDX_FAULT1))) begin // RQ16
                next_fault_cfg[c] = {avs_writedata[7:4], 4'h0};
                // Write zero clears, one keeps
                if (!avs_writedata[FB_OPEN_FL]) next_open_flag[c] = 1'b0; // RQ17
                if (!avs_writedata[FB_SHORT_FL]) next_short_flag[c] = 1'b0; // RQ17
            end
            // Hardware set wins over a same-cycle clear
            if (short_event[c]) next_short_flag[c] = 1'b1; // RQ5 RQ7
            if (open_event[c]) next_open_flag[c] = 1'b1; // RQ8
        end
        if (wlane && a == widx(IDX_DIVSEL0)) next_divsel0 = {6'h00, avs_writedata[1:0]};
        if (wlane && a == widx(IDX_GENCFG1)) next_gencfg1 = avs_writedata[7:0];
        if (wlane && a == widx(IDX_LEDCFG1)) next_ledcfg1 = {avs_writedata[7], 2'h0,
                                                             avs_writedata[4:0]};
        if (wlane && a == widx(IDX_IRQ_ENABLE)) next_irq_enable = avs_writedata[3:0];
        if (wlane && a == widx(IDX_IRQ_CLEAR)) next_irq_status = irq_status & ~avs_writedata[3:0];
        // Summary events, set wins over clear
        next_irq_status = next_irq_status | {open_event[1], short_event[1],
                                             open_event[0], short_event[0]};
    end

    // Read mux
    logic [7:0] rd_val;

    always_comb begin
        case (a)
            widx(IDX_FAULT0):     rd_val = {fault_cfg[0][7:4], open_live[0], short_live[0],
                                            open_flag[0], short_flag[0]};
            widx(IDX_FAULT1):     rd_val = {fault_cfg[1][7:4], open_live[1], short_live[1],
                                            open_flag[1], short_flag[1]};
            widx(IDX_DIVSEL0):    rd_val = divsel0;
            widx(IDX_GENCFG1):    rd_val = gencfg1;
            widx(IDX_LEDCFG1):    rd_val = ledcfg1;
            widx(IDX_IRQ_STATUS): rd_val = {4'h0, irq_status};
            widx(IDX_IRQ_ENABLE): rd_val = {4'h0, irq_enable};
            default:              rd_val = 8'h00;
        endcase
    end

    // Flag-level interrupt: per-channel fault enable plus summary enable
    logic next_irq;
    logic [3:0] gated;

    always_comb begin
        gated = next_irq_status & next_irq_enable;
        next_irq = (gated[IB_SHORT0] & next_fault_cfg[0][FB_IRQ_EN]) | // RQ5 RQ6
                   (gated[IB_OPEN0]  & next_fault_cfg[0][FB_IRQ_EN]) | // RQ8
                   (gated[IB_SHORT1] & next_fault_cfg[1][FB_IRQ_EN]) |
                   (gated[IB_OPEN1]  & next_fault_cfg[1][FB_IRQ_EN]);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pend            <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            avs_response    <= 2'h0;
            fault_cfg[0]    <= RST_FAULT;
            fault_cfg[1]    <= RST_FAULT;
            divsel0         <= RST_DIVSEL;
            gencfg1         <= RST_GENCFG;
            ledcfg1         <= RST_LEDCFG;
            open_flag       <= 2'h0;
            short_flag      <= 2'h0;
            irq_status      <= RST_IRQ;
            irq_enable      <= RST_IRQ;
            irq             <= 1'b0;
        end else begin
            pend            <= next_pend;
            // Waitrequest drops in the cycle the answer is presented
            avs_waitrequest <= ~next_pend;
            avs_readdata    <= (avs_read & ~pend) ? {24'h000000, rd_val} : avs_readdata;
            avs_response    <= ((avs_read | avs_write) & ~pend & ~hit) ? 2'h2 : 2'h0;
            fault_cfg       <= next_fault_cfg;
            divsel0         <= next_divsel0;
            gencfg1         <= next_gencfg1;
            ledcfg1         <= next_ledcfg1;
            open_flag       <= next_open_flag;
            short_flag      <= next_short_flag;
            irq_status      <= next_irq_status;
            irq_enable      <= next_irq_enable;
            irq             <= next_irq;
        end
    end

    // Analog and pin controls, all registered
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sense_divider_select     <= DIV_FIFTH;
            i2c_clock_route_enable   <= 1'b0;
            pin1_converter_enable    <= 1'b0;
            spi_clock_route_enable   <= 1'b0;
            pin1_port_enable         <= 1'b0;
            green_pwm_route_enable   <= 1'b0;
            pin1_attenuator_enable   <= 1'b0;
            pin1_input_buffer_enable <= 1'b0;
            pin1_pullup_enable       <= 1'b0;
            pin1_current_sink_enable <= 1'b0;
            pin1_fullscale_trim      <= 5'h00;
            pin1_sink_drive          <= 1'b0;
        end else begin
            sense_divider_select     <= next_divsel0[1:0]; // RQ9
            i2c_clock_route_enable   <= next_gencfg1[GB_I2C_CLK]; // RQ10
            spi_clock_route_enable   <= next_gencfg1[GB_SPI_CLK]; // RQ10
            pin1_port_enable         <= next_gencfg1[GB_PORT]; // RQ11
            pin1_attenuator_enable   <= next_gencfg1[GB_ATTEN]; // RQ12
            pin1_converter_enable    <= next_gencfg1[GB_ADC]; // RQ13
            green_pwm_route_enable   <= next_gencfg1[GB_PWM];
            pin1_input_buffer_enable <= next_gencfg1[GB_INBUF];
            pin1_pullup_enable       <= next_gencfg1[GB_PULLUP];
            pin1_current_sink_enable <= next_ledcfg1[LB_SINK_EN]; // RQ14
            pin1_fullscale_trim      <= next_ledcfg1[LB_TRIM_LSB +: LB_TRIM_W]; // RQ15
            // PWM drives the sink only while sink enabled
            pin1_sink_drive          <= led_pwm_output & next_ledcfg1[LB_SINK_EN]; // RQ14
        end
    end

    AST_SHORT_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        short_event[0] |=> short_flag[0]) // RQ5
        else $error("short flag not set by event");
    AST_NO_IRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!next_fault_cfg[0][FB_IRQ_EN] && !next_fault_cfg[1][FB_IRQ_EN]) |=> !irq) // RQ6
        else $error("interrupt with fault interrupts disabled");
    AST_SHORT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (short_flag[0] && !(wlane && a == widx(IDX_FAULT0))) |=> short_flag[0]) // RQ7
        else $error("short flag dropped without software");
    AST_OPEN_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (open_flag[1] && !(wlane && a == widx(IDX_FAULT1))) |=> open_flag[1]) // RQ8
        else $error("open flag dropped without software");
    AST_DIVSEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wlane && a == widx(IDX_DIVSEL0)) |=> ##1 sense_divider_select == $past(avs_writedata[1:0], 2)) // RQ9
        else $error("divider select not applied");
    AST_TRIM: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wlane && a == widx(IDX_LEDCFG1)) |=> pin1_fullscale_trim == $past(avs_writedata[4:0])) // RQ15
        else $error("trim not applied");
    AST_CLR_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wlane && a == widx(IDX_FAULT0) && avs_writedata[FB_SHORT_FL] && short_flag[0])
        |=> short_flag[0]) // RQ17
        else $error("write of one cleared a flag");
    AST_LIVE_RO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wlane && a == widx(IDX_FAULT1)) |=> fault_cfg[1][3:0] == 4'h0) // RQ16
        else $error("live status bits took a write");
    AST_SINK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ledcfg1[LB_SINK_EN] |-> !pin1_sink_drive || $past(ledcfg1[LB_SINK_EN] == 1'b0) == 1'b0) // RQ14
        else $error("sink driven while disabled");
    AST_ROUTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(gencfg1[GB_SPI_CLK]) |-> spi_clock_route_enable) // RQ10
        else $error("spi clock route not following register");

endmodule // hvpl_regs
`default_nettype wire

// file: testbench/hv_pin_led_fault_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hv_pin_led_fault_config_tb_top
    import hvpl_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        mid_pwm = 1'b0;
    logic        led_pwm_output = 1'b0;
    logic [1:0]  open_sense = 2'h0;
    logic [1:0]  short_sense = 2'h0;
    logic [1:0]  sense_divider_select;
    wire [7:0]   cfg_out;
    logic [3:0]  avs_byteenable = 4'h1;
    logic        pin1_current_sink_enable;
    logic [4:0]  pin1_fullscale_trim;
    logic        pin1_sink_drive;
    logic        irq;
    logic [3:0]  pwm_cnt = 4'h0;
    int          fail_count = 0;
    int          checks = 0;

    // 20 ns clock
    always #10 clk_sys = ~clk_sys;

    // Mid-period strobe every 16 cycles
    always @(posedge clk_sys) begin
        pwm_cnt <= pwm_cnt + 4'h1;
        mid_pwm <= (pwm_cnt == 4'h7);
    end

    hvpl_regs dut (
        .clk_sys                  (clk_sys),
        .rst_n                    (rst_n),
        .avs_address              (avs_address),
        .avs_read                 (avs_read),
        .avs_write                (avs_write),
        .avs_writedata            (avs_writedata),
        .avs_byteenable           (avs_byteenable),
        .avs_readdata             (avs_readdata),
        .avs_waitrequest          (avs_waitrequest),
        .avs_response             (avs_response),
        .mid_pwm                  (mid_pwm),
        .led_pwm_output           (led_pwm_output),
        .open_sense               (open_sense),
        .short_sense              (short_sense),
        .sense_divider_select     (sense_divider_select),
        .i2c_clock_route_enable   (cfg_out[7]),
        .pin1_converter_enable    (cfg_out[6]),
        .spi_clock_route_enable   (cfg_out[5]),
        .pin1_port_enable         (cfg_out[4]),
        .green_pwm_route_enable   (cfg_out[3]),
        .pin1_attenuator_enable   (cfg_out[2]),
        .pin1_input_buffer_enable (cfg_out[1]),
        .pin1_pullup_enable       (cfg_out[0]),
        .pin1_current_sink_enable (pin1_current_sink_enable),
        .pin1_fullscale_trim      (pin1_fullscale_trim),
        .pin1_sink_drive          (pin1_sink_drive),
        .irq                      (irq)
    );

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One bus access; request held until waitrequest is seen low
    task automatic bus_xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wdata,
                            output logic [31:0] rdata, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address   <= {idx[13:0], 2'b00};
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= {24'h00_0000, wdata};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            $display("MISMATCH at %0t: bus answer missing", $time);
            conclude();
        end
        rdata = avs_readdata;
        resp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic [1:0]  s;
        bus_xfer(1'b1, idx, d, r, s);
        // Registered outputs change on the edge the write lands; wait one edge to see them
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] eresp);
        logic [31:0] r;
        logic [1:0]  s;
        bus_xfer(1'b0, idx, 8'h00, r, s);
        chk(r, {24'h00_0000, exp}, "read data");
        chk({30'h0, s}, {30'h0, eresp}, "response");
    endtask

    // Count mid-period strobes, then let the result settle
    task automatic wait_mid(input int n);
        int k;
        int t;
        k = 0;
        t = 0;
        while (k < n && t < 64 * n) begin
            @(posedge clk_sys);
            t++;
            if (mid_pwm === 1'b1) k++;
        end
        if (k < n) begin
            fail_count++;
            $display("MISMATCH at %0t: mid period strobe missing", $time);
            conclude();
        end
        repeat (3) @(posedge clk_sys);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values, read-only live bits, unmapped place
        rd(IDX_FAULT0, RST_FAULT, 2'h0);
        rd(IDX_DIVSEL0, RST_DIVSEL, 2'h0);
        rd(IDX_GENCFG1, RST_GENCFG, 2'h0);
        rd(IDX_LEDCFG1, RST_LEDCFG, 2'h0);
        rd(IDX_IRQ_STATUS, 8'h00, 2'h0);
        wr(IDX_FAULT1, 8'h0C);
        rd(IDX_FAULT1, 8'h00, 2'h0);
        rd(16'h3FFF, 8'h00, 2'h2);
        // Every divider code reaches its output
        for (int g = 0; g < 4; g++) begin
            wr(IDX_DIVSEL0, 8'(g));
            rd(IDX_DIVSEL0, 8'(g), 2'h0);
            chk({30'h0, sense_divider_select}, 32'(g), "divider");
        end
        // Pin routing enables, two opposite patterns
        wr(IDX_GENCFG1, 8'hA5);
        rd(IDX_GENCFG1, 8'hA5, 2'h0);
        chk({24'h0, cfg_out}, 32'hA5, "routing");
        wr(IDX_GENCFG1, 8'h5A);
        chk({24'h0, cfg_out}, 32'h5A, "routing");
        // Write with lane 0 off must be ignored
        avs_byteenable <= 4'h0;
        wr(IDX_GENCFG1, 8'h00);
        avs_byteenable <= 4'h1;
        rd(IDX_GENCFG1, 8'h5A, 2'h0);
        // Sink enable gates the PWM; trim at full value
        led_pwm_output <= 1'b1;
        wr(IDX_LEDCFG1, 8'h9F);
        chk({31'h0, pin1_current_sink_enable}, 32'h1, "sink enable");
        chk({27'h0, pin1_fullscale_trim}, 32'h1F, "trim");
        repeat (2) @(posedge clk_sys);
        chk({31'h0, pin1_sink_drive}, 32'h1, "sink drive");
        wr(IDX_LEDCFG1, 8'h0A);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, pin1_sink_drive}, 32'h0, "sink drive off");
        chk({27'h0, pin1_fullscale_trim}, 32'h0A, "trim");
        // Short fault with interrupt on
        wr(IDX_IRQ_ENABLE, 8'h0F);
        wr(IDX_FAULT0, 8'h70);
        short_sense <= 2'h1;
        wait_mid(2);
        rd(IDX_FAULT0, 8'h75, 2'h0);
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd(IDX_IRQ_STATUS, 8'h01, 2'h0);
        short_sense <= 2'h0;
        wait_mid(2);
        rd(IDX_FAULT0, 8'h71, 2'h0);
        wr(IDX_FAULT0, 8'h71);
        rd(IDX_FAULT0, 8'h71, 2'h0);
        wr(IDX_FAULT0, 8'h70);
        rd(IDX_FAULT0, 8'h70, 2'h0);
        wr(IDX_IRQ_CLEAR, 8'h0F);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // Detectors off: live status held low
        wr(IDX_FAULT0, 8'h40);
        open_sense <= 2'h1;
        short_sense <= 2'h1;
        wait_mid(3);
        rd(IDX_FAULT0, 8'h40, 2'h0);
        chk({31'h0, irq}, 32'h0, "no irq when off");
        // Interrupt off: open flag only latches
        short_sense <= 2'h0;
        wr(IDX_FAULT0, 8'h20);
        wait_mid(2);
        rd(IDX_FAULT0, 8'h2A, 2'h0);
        chk({31'h0, irq}, 32'h0, "no irq latched");
        open_sense <= 2'h0;
        wait_mid(2);
        rd(IDX_FAULT0, 8'h22, 2'h0);
        // Filter on channel 1: slow to assert and release
        wr(IDX_FAULT1, 8'hB0);
        short_sense <= 2'h2;
        wait_mid(1);
        rd(IDX_FAULT1, 8'hB0, 2'h0);
        wait_mid(FILTER_PERIODS + 1);
        rd(IDX_FAULT1, 8'hB5, 2'h0);
        short_sense <= 2'h0;
        wait_mid(1);
        rd(IDX_FAULT1, 8'hB5, 2'h0);
        wait_mid(FILTER_PERIODS + 1);
        rd(IDX_FAULT1, 8'hB1, 2'h0);
        conclude();
    end
endmodule // hv_pin_led_fault_config_tb_top
`default_nettype wire
